// ===== hw/foas_pkg.sv
// package: shared constants and types for the first-out alarm sequencer
package foas_pkg;

    // channel sequence states, one-hot
    typedef enum logic [4:0] {
        FOAS_NORMAL    = 5'h01, // idle, lamp off
        FOAS_FIRST     = 5'h02, // first-out alarm, flashing, audible
        FOAS_SUBSEQ    = 5'h04, // later alarm, steady, audible
        FOAS_FIRST_SIL = 5'h08, // first-out silenced, still flashing
        FOAS_ACKED     = 5'h10  // acknowledged, steady, silent
    } foas_state_t;

    // operator pushbuttons as one group
    typedef struct packed {
        logic silence;
        logic acknowledge;
        logic reset;
    } foas_buttons_t;

    // default channel count
    localparam int FOAS_CHANNELS = 16;
    // flash half period in core_clk cycles (250 MHz, 250 ms)
    localparam int FOAS_FLASH_MS = 250;
    localparam int FOAS_CLK_KHZ = 250000;
    localparam int FOAS_FLASH_CYCLES = FOAS_FLASH_MS * FOAS_CLK_KHZ;
    // reset value of the audible output
    localparam logic FOAS_OUT_RESET = 1'b0;

endpackage

// ===== hw/foas_sync2.sv
// two-flop synchroniser, one bit wide per instance
`timescale 1ns/100ps
module foas_sync2 (
    core_clk,
    rst_n,
    clk_en,
    d_in,
    q_out
);
    input wire logic core_clk;
    input wire logic rst_n;
    input wire logic clk_en;
    input wire logic d_in;
    output logic q_out;

    logic meta_reg; // first stage, read only by second stage
    logic meta_next;
    logic q_next;

    // next values; state frozen while clock enable is low
    always_comb begin
        meta_next = clk_en ? d_in : meta_reg;
        q_next = clk_en ? meta_reg : q_out;
    end

    // registers only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            q_out <= q_next;
        end
    end
endmodule

// ===== hw/foas_sequencer.sv
// per-channel first-out manual-reset alarm sequencer with silence button
`timescale 1ns/100ps
// Notes on behaviour
// (R1) first abnormal from all-normal: flashing, audible
// (R2) later alarms lock in steady and audible
// (R3) silence stops horn, first keeps flashing
// (R4) silence button separate from acknowledge
// (R5) acknowledge moves all alarms to steady acknowledged
// (R6) acknowledged stays lit until normal plus reset
module foas_sequencer
    import foas_pkg::*;
#(
    parameter int CHANNELS = FOAS_CHANNELS,
    parameter int FLASH_CYCLES = FOAS_FLASH_CYCLES
) (
    core_clk,
    rst_n,
    clk_en,
    process_abnormal,
    buttons,
    lamp_on,
    first_out,
    audible_on
);
    input wire logic core_clk;
    input wire logic rst_n;
    input wire logic clk_en;
    input wire logic [CHANNELS-1:0] process_abnormal; // field contacts, async
    input wire foas_buttons_t buttons; // operator pushbuttons, async
    output logic [CHANNELS-1:0] lamp_on; // channel indicators
    output logic [CHANNELS-1:0] first_out; // first-out flag per channel
    output logic audible_on; // shared horn

    localparam int CW = $clog2(FLASH_CYCLES + 1);
    localparam logic [CW-1:0] FLASH_LAST = CW'(FLASH_CYCLES - 1);

    logic [CHANNELS-1:0] abn_sync; // synchronised contacts
    logic [2:0] btn_sync; // synchronised silence, ack, reset
    logic [2:0] btn_prev_reg; // last button level for edge detect
    logic [2:0] btn_prev_next;
    logic sil_press; // one-cycle press pulses
    logic ack_press;
    logic rst_press;
    // previous button levels read as held until the synchronisers hold real levels;
    // otherwise a button held through reset would look like a fresh press
    logic [1:0] settle_reg; // enabled cycles since reset, stops at two
    logic [1:0] settle_next;
    logic settled; // synchroniser outputs now carry button levels

    // contacts cross into core_clk through two flops each
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_abn
            foas_sync2 u_sync (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .d_in(process_abnormal[gi]),
                .q_out(abn_sync[gi])
            );
        end
        for (gi = 0; gi < 3; gi++) begin : g_btn
            foas_sync2 u_sync (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .d_in(gi == 2 ? buttons.silence : (gi == 1 ? buttons.acknowledge : buttons.reset)),
                .q_out(btn_sync[gi])
            );
        end
    endgenerate

    // press edges; silence has its own input apart from acknowledge
    always_comb begin
        settled = (settle_reg == 2'h2);
        settle_next = settle_reg;
        btn_prev_next = btn_prev_reg;
        if (clk_en) begin
            // count two enabled cycles, then stop
            settle_next = settled ? settle_reg : settle_reg + 2'h1;
            // forced high until settled, so a held button shows no edge
            btn_prev_next = settled ? btn_sync : 3'h7;
        end
        sil_press = clk_en & btn_sync[2] & ~btn_prev_reg[2]; // [R4]
        ack_press = clk_en & btn_sync[1] & ~btn_prev_reg[1];
        rst_press = clk_en & btn_sync[0] & ~btn_prev_reg[0];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            btn_prev_reg <= 3'h7; // a button held through reset gives no press
            settle_reg <= 2'h0;
        end else begin
            btn_prev_reg <= btn_prev_next;
            settle_reg <= settle_next;
        end
    end

    // flash timebase; free running so all flashing lamps blink in step
    logic [CW-1:0] flash_cnt_reg;
    logic [CW-1:0] flash_cnt_next;
    logic flash_phase_reg;
    logic flash_phase_next;

    always_comb begin
        flash_cnt_next = flash_cnt_reg;
        flash_phase_next = flash_phase_reg;
        if (clk_en) begin
            if (flash_cnt_reg >= FLASH_LAST) begin
                flash_cnt_next = '0;
                flash_phase_next = ~flash_phase_reg;
            end else begin
                flash_cnt_next = flash_cnt_reg + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_cnt_reg <= '0;
            flash_phase_reg <= 1'b0;
        end else begin
            flash_cnt_reg <= flash_cnt_next;
            flash_phase_reg <= flash_phase_next;
        end
    end

    // channel state machines
    foas_state_t st_reg [CHANNELS];
    foas_state_t st_next [CHANNELS];
    logic all_normal; // no channel in any alarm state
    logic [CHANNELS-1:0] newly; // channels turning abnormal from normal
    logic [CHANNELS-1:0] first_pick; // lowest newly-abnormal channel wins
    logic [CHANNELS-1:0] lamp_next;
    logic [CHANNELS-1:0] fo_next;
    logic aud_next;

    always_comb begin
        all_normal = 1'b1;
        newly = '0;
        for (int i = 0; i < CHANNELS; i++) begin
            if (st_reg[i] != FOAS_NORMAL) begin
                all_normal = 1'b0;
            end
            newly[i] = (st_reg[i] == FOAS_NORMAL) & abn_sync[i];
        end
        // simultaneous first alarms: lowest index taken as first out
        first_pick = newly & (~newly + CHANNELS'(1));
    end

    always_comb begin
        aud_next = 1'b0;
        for (int i = 0; i < CHANNELS; i++) begin
            st_next[i] = st_reg[i];
            if (clk_en) begin
                case (st_reg[i])
                    FOAS_NORMAL: begin
                        if (newly[i] && all_normal && first_pick[i]) begin
                            st_next[i] = FOAS_FIRST; // [R1]
                        end else if (newly[i]) begin
                            st_next[i] = FOAS_SUBSEQ; // [R2]
                        end
                    end
                    FOAS_FIRST: begin
                        // acknowledge wins over silence pressed together
                        if (ack_press) begin
                            st_next[i] = FOAS_ACKED; // [R5]
                        end else if (sil_press) begin
                            st_next[i] = FOAS_FIRST_SIL; // [R3]
                        end
                    end
                    FOAS_SUBSEQ: begin
                        if (ack_press || sil_press) begin
                            st_next[i] = FOAS_ACKED; // [R3] [R5]
                        end
                    end
                    FOAS_FIRST_SIL: begin
                        if (ack_press) begin
                            st_next[i] = FOAS_ACKED; // [R5]
                        end
                    end
                    FOAS_ACKED: begin
                        // reset only clears channels whose contact is normal
                        if (rst_press && !abn_sync[i]) begin
                            st_next[i] = FOAS_NORMAL; // [R6]
                        end
                    end
                    default: begin
                        st_next[i] = FOAS_NORMAL;
                    end
                endcase
            end
        end
        // outputs from the next state so they change on the same edge as the state register
        for (int i = 0; i < CHANNELS; i++) begin
            fo_next[i] = (st_next[i] == FOAS_FIRST) || (st_next[i] == FOAS_FIRST_SIL);
            lamp_next[i] = fo_next[i] ? flash_phase_next : (st_next[i] != FOAS_NORMAL); // [R2]
            if (st_next[i] == FOAS_FIRST || st_next[i] == FOAS_SUBSEQ) begin
                aud_next = 1'b1; // [R1] [R2]
            end
        end
        if (!clk_en) begin
            aud_next = audible_on;
            lamp_next = lamp_on;
            fo_next = first_out;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < CHANNELS; i++) begin
                st_reg[i] <= FOAS_NORMAL;
            end
            lamp_on <= '0;
            first_out <= '0;
            audible_on <= FOAS_OUT_RESET;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                st_reg[i] <= st_next[i];
            end
            lamp_on <= lamp_next;
            first_out <= fo_next;
            audible_on <= aud_next;
        end
    end
endmodule

// ===== testbench/foas_sequencer_props.sv
// checker: port-level assertions for the alarm sequencer
`timescale 1ns/100ps
module foas_sequencer_props
    import foas_pkg::*;
#(
    parameter int CHANNELS = FOAS_CHANNELS,
    parameter int FLASH_CYCLES = FOAS_FLASH_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [CHANNELS-1:0] process_abnormal,
    input wire foas_buttons_t buttons,
    input wire logic [CHANNELS-1:0] lamp_on,
    input wire logic [CHANNELS-1:0] first_out,
    input wire logic audible_on
);
    logic [7:0] rst_age_reg; // cycles since reset button, saturating
    logic [31:0] hold_reg; // cycles the first-out lamp held still
    logic [CHANNELS-1:0] lamp_prev_reg; // lamps one cycle back
    // helper counters; a stuck flasher makes hold_reg run away
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_age_reg <= 8'hFF;
            hold_reg <= '0;
            lamp_prev_reg <= '0;
        end else begin
            rst_age_reg <= buttons.reset ? 8'h00 : (rst_age_reg == 8'hFF ? rst_age_reg : rst_age_reg + 8'h01);
            // a frozen block holds its flasher, so the count holds too
            hold_reg <= !clk_en ? hold_reg :
                ((|first_out && ((lamp_on ^ lamp_prev_reg) & first_out) == '0) ? hold_reg + 1 : '0);
            lamp_prev_reg <= lamp_on;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // silence press alone while a first-out exists
    sequence s_silence_press;
        $rose(buttons.silence) && !buttons.acknowledge && !buttons.reset && |first_out;
    endsequence
    sequence s_ack_press;
        $rose(buttons.acknowledge);
    endsequence
    a_first_sounds: assert property ($rose(|first_out) |-> audible_on)
        else $error("first-out without horn");
    a_flash_period: assert property (hold_reg <= FLASH_CYCLES)
        else $error("first-out lamp not flashing");
    a_single_first: assert property ($onehot0(first_out))
        else $error("more than one first-out");
    a_horn_has_alarm: assert property (audible_on |-> (|lamp_on || |first_out))
        else $error("horn with no alarm shown");
    a_silence_quiet: assert property (s_silence_press |-> ##[3:4] !audible_on)
        else $error("silence left horn on");
    a_silence_keeps: assert property (s_silence_press |-> ##4 (|first_out))
        else $error("silence cleared first-out");
    a_ack_clears: assert property (s_ack_press |-> ##4 (first_out == '0 && !audible_on))
        else $error("ack left first-out or horn");
    a_reset_only: assert property (((lamp_prev_reg & ~lamp_on & ~$past(first_out)) != '0) |-> rst_age_reg <= 8'h05)
        else $error("steady lamp dropped without reset");
endmodule
bind foas_sequencer foas_sequencer_props #(.CHANNELS(CHANNELS), .FLASH_CYCLES(FLASH_CYCLES)) foas_sequencer_props_inst (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .process_abnormal(process_abnormal),
    .buttons(buttons), .lamp_on(lamp_on), .first_out(first_out), .audible_on(audible_on));

// ===== testbench/foas_field.sv
// field model: process contacts and operator pushbuttons
`timescale 1ns/100ps
module foas_field
    import foas_pkg::*;
#(
    parameter int CHANNELS = FOAS_CHANNELS
) (
    input wire logic core_clk,
    output logic [CHANNELS-1:0] process_abnormal,
    output foas_buttons_t buttons
);
    initial begin
        process_abnormal = '0;
        buttons = '0;
    end
    // contact level, changed off the sampling edge
    task automatic contact(input int ch, input logic lvl);
        @(negedge core_clk);
        process_abnormal[ch] = lvl;
    endtask
    // whole contact vector at once, for alarms that arrive together
    task automatic contacts(input logic [CHANNELS-1:0] lvl);
        @(negedge core_clk);
        process_abnormal = lvl;
    endtask
    // one press, held past the sync, then a low gap so the next one counts
    task automatic press(input foas_buttons_t b);
        @(negedge core_clk);
        buttons = b;
        repeat (4) @(negedge core_clk);
        buttons = '0;
        repeat (6) @(negedge core_clk);
    endtask
endmodule

// ===== testbench/first_out_alarm_sequencer_tb_top.sv
// testbench: scenario tasks for the alarm sequencer
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module first_out_alarm_sequencer_tb_top;
    import foas_pkg::*;
    logic core_clk = 1'b0; // 250 MHz
    logic rst_n = 1'b0;
    logic clk_en = 1'b1; // low freezes the block
    logic [15:0] process_abnormal;
    foas_buttons_t buttons;
    logic [15:0] lamp_on;
    logic [15:0] first_out;
    logic audible_on;
    logic phase; // flash phase sample
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    foas_field #(.CHANNELS(16)) foas_field_inst (.core_clk(core_clk), .process_abnormal(process_abnormal),
        .buttons(buttons));
    // short flash count keeps the run brief
    foas_sequencer #(.CHANNELS(16), .FLASH_CYCLES(4)) foas_sequencer_inst (.core_clk(core_clk), .rst_n(rst_n),
        .clk_en(clk_en), .process_abnormal(process_abnormal), .buttons(buttons), .lamp_on(lamp_on),
        .first_out(first_out), .audible_on(audible_on));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // first alarm flashes and sounds, later one steady and sounding
    task automatic t_first_then_later();
        foas_field_inst.contact(3, 1'b1);
        repeat (6) @(negedge core_clk);
        `CHK("first", 16'h0008, first_out)
        `CHK("horn", 1'b1, audible_on)
        foas_field_inst.contact(7, 1'b1);
        repeat (6) @(negedge core_clk);
        `CHK("first", 16'h0008, first_out)
        `CHK("lamp7", 1'b1, lamp_on[7])
        `CHK("horn", 1'b1, audible_on)
    endtask
    // silence: horn off, first keeps flashing, later goes acknowledged
    task automatic t_silence();
        foas_field_inst.press(foas_buttons_t'(3'h4));
        `CHK("horn", 1'b0, audible_on)
        `CHK("first", 16'h0008, first_out)
        `CHK("lamp7", 1'b1, lamp_on[7])
        phase = lamp_on[3];
        repeat (4) @(negedge core_clk);
        `CHK("flash", ~phase, lamp_on[3])
    endtask
    // ack after silence, then reset refused while a contact stays abnormal
    task automatic t_ack_reset();
        foas_field_inst.press(foas_buttons_t'(3'h2));
        `CHK("first", 16'h0000, first_out)
        `CHK("lamps", 16'h0088, lamp_on)
        foas_field_inst.contact(3, 1'b0);
        foas_field_inst.press(foas_buttons_t'(3'h1));
        `CHK("lamps", 16'h0080, lamp_on)
        foas_field_inst.contact(7, 1'b0);
        foas_field_inst.press(foas_buttons_t'(3'h1));
        `CHK("lamps", 16'h0000, lamp_on)
    endtask
    // momentary alarm locks in, ack without silence, then reset
    task automatic t_ack_direct();
        foas_field_inst.contact(2, 1'b1);
        foas_field_inst.contact(2, 1'b0);
        repeat (6) @(negedge core_clk);
        `CHK("first", 16'h0004, first_out)
        foas_field_inst.press(foas_buttons_t'(3'h2));
        `CHK("lamps", 16'h0004, lamp_on)
        `CHK("horn", 1'b0, audible_on)
        foas_field_inst.press(foas_buttons_t'(3'h1));
        `CHK("lamps", 16'h0000, lamp_on)
    endtask
    // simultaneous alarms pick the lowest; enable low freezes all; ack beats silence
    task automatic t_pair_freeze();
        foas_field_inst.contacts(16'h0220);
        repeat (6) @(negedge core_clk);
        `CHK("first", 16'h0020, first_out)
        `CHK("lamp9", 1'b1, lamp_on[9])
        `CHK("horn", 1'b1, audible_on)
        clk_en = 1'b0;
        phase = lamp_on[5];
        foas_field_inst.contact(11, 1'b1);
        repeat (3) @(negedge core_clk);
        `CHK("frozen5", phase, lamp_on[5])
        `CHK("frozen11", 1'b0, lamp_on[11])
        clk_en = 1'b1;
        repeat (6) @(negedge core_clk);
        `CHK("lamp11", 1'b1, lamp_on[11])
        `CHK("first", 16'h0020, first_out)
        foas_field_inst.press(foas_buttons_t'(3'h6));
        `CHK("first", 16'h0000, first_out)
        `CHK("horn", 1'b0, audible_on)
        `CHK("lamps", 16'h0A20, lamp_on)
        foas_field_inst.contacts(16'h0000);
        foas_field_inst.press(foas_buttons_t'(3'h1));
        `CHK("lamps", 16'h0000, lamp_on)
    endtask
    initial begin
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        t_first_then_later();
        t_silence();
        t_ack_reset();
        t_ack_direct();
        t_pair_freeze();
        tally_and_finish();
    end
endmodule
